// file: hw/adsq_params.svh
`ifndef ADSQ_PARAMS_SVH
`define ADSQ_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define ADSQ_OFF_DATA0     8'h00
`define ADSQ_OFF_LOW6      8'h20
`define ADSQ_OFF_LOW7      8'h24
`define ADSQ_OFF_UP6       8'h28
`define ADSQ_OFF_UP7       8'h2c
`define ADSQ_OFF_HIT       8'h30
`define ADSQ_OFF_CTRL      8'h34
`define ADSQ_OFF_INTC      8'h38
`define ADSQ_OFF_VEC       8'h3c

// Control register field positions.
`define ADSQ_CTL_GO        0
`define ADSQ_CTL_REPEAT    1
`define ADSQ_CTL_BIAS      2
`define ADSQ_CTL_TMR_EN    3
`define ADSQ_CTL_EXT_EN    4
`define ADSQ_CTL_FIRST_LO  5

// Interrupt control field positions and reset values.
`define ADSQ_INT_EOC       7
`define ADSQ_INT_ALARM     6
`define ADSQ_INT_EOC_MSK   5
`define ADSQ_INT_ALM_MSK   4
`define ADSQ_INTC_RST      8'h0f
`define ADSQ_HIT_LOW_ONES  4'hf
`define ADSQ_CTRL_RST      8'h00

// Conversion timing: cycles per channel conversion.
`define ADSQ_CONV_CYCLES   16'd64
`define ADSQ_LAST_CH       3'h7
`define ADSQ_CH6           3'h6

// AXI response codes.
`define ADSQ_RESP_OKAY     2'b00
`define ADSQ_RESP_SLVERR   2'b10

`endif

// file: hw/adsq_pkg.sv
package adsq_pkg;
	typedef enum logic [2:0] {
		ADSQ_IDLE = 3'b001,
		ADSQ_CONV = 3'b010,
		ADSQ_DONE = 3'b100
	} adsq_state_e;
	typedef logic [7:0] adsq_byte_t;
endpackage

// file: hw/adsq_result_mem.sv
`timescale 1ns/1ns
// ********************************************
// Eight-entry result store, registered read.
// ********************************************
module adsq_result_mem (
	input  wire logic       ref_clk_i, // Core clock.
	input  wire logic       wr_en_i,   // Store one result.
	input  wire logic [2:0] wr_ch_i,   // Channel being stored.
	input  wire logic [7:0] wr_data_i, // Result code.
	input  wire logic [2:0] rd_ch_i,   // Channel to read.
	output logic      [7:0] rd_data_o  // Registered read data.
);
	logic [7:0] mem_q [0:7];

	// A new result replaces the old one outright.
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_ch_i] <= wr_data_i;
		end
	end

	// Read data registered so the bus sees a stable word.
	always_ff @(posedge ref_clk_i) begin
		rd_data_o <= mem_q[rd_ch_i];
	end
endmodule

// file: hw/adsq_top.sv
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - Repeat mode bit one selects continuous scanning, zero selects single.
// - Scan starts at first channel field, steps up, ends at channel 7.
// - Go bit set by software or hardware starts conversions in order.
// - Single mode: channel 7 done clears go, flags end, waits idle.
// - Continuous mode restarts at first channel until software clears go.
// - End-of-conversion flag is raised whenever channel 7 completes.
// - Each conversion overwrites that channel's stored result.
// - External pin and timer event, each enabled, are ORed as triggers.
// - Enabled trigger sets go; single mode clears it after each scan.
// - Continuous mode acts on first trigger only, ignores later ones.
// - Triggers arriving while go is still set are ignored.
// - Channels 6 and 7 in range when below upper, at/above lower.
// - Out of range sets alarm flag, matching hit bit, and request when alarm mask set.
// - Four 8-bit thresholds live in four writable registers.
// - Hit register upper four bits are status, lower four read one.
// - Hit bits reset to zero, set on out-of-range, cleared with alarm.
// - Bias enable resets to zero and drops during processor halt.
// - Vector bit tells which of the two sources is requesting.
// - Alarm request is served first; end request stays pending.
// - Software setting either flag raises a software request.
// - Any control write with byte lane 0 strobed aborts the scan and restarts sequencing.
`include "adsq_params.svh"
module adsq_top (
	input  wire logic        ref_clk_i,      // Core clock, 125 MHz.
	input  wire logic        resetn_i,       // Synchronous reset, low.
	input  wire logic [31:0] s_axi_awaddr,   // Write address.
	input  wire logic        s_axi_awvalid,  // Write address valid.
	output logic             s_axi_awready,  // Write address ready.
	input  wire logic [31:0] s_axi_wdata,    // Write data.
	input  wire logic [3:0]  s_axi_wstrb,    // Write strobes.
	input  wire logic        s_axi_wvalid,   // Write data valid.
	output logic             s_axi_wready,   // Write data ready.
	output logic [1:0]       s_axi_bresp,    // Write response.
	output logic             s_axi_bvalid,   // Write response valid.
	input  wire logic        s_axi_bready,   // Write response ready.
	input  wire logic [31:0] s_axi_araddr,   // Read address.
	input  wire logic        s_axi_arvalid,  // Read address valid.
	output logic             s_axi_arready,  // Read address ready.
	output logic [31:0]      s_axi_rdata,    // Read data.
	output logic [1:0]       s_axi_rresp,    // Read response.
	output logic             s_axi_rvalid,   // Read data valid.
	input  wire logic        s_axi_rready,   // Read data ready.
	input  wire logic        external_trigger_pin_i, // Trigger pin.
	input  wire logic        timer_trigger_event_i,  // Timer event.
	input  wire logic        halt_i,         // Processor in halt.
	input  wire logic [7:0]  conv_result_i,  // Analog core result.
	output logic [2:0]       channel_o,      // Channel being converted.
	output logic             converting_o,   // Conversion running.
	output logic             analog_bias_enable_o, // Analog bias on.
	output logic             irq_req_o,      // Request to interrupt unit.
	output logic             irq_vec_o       // 1 alarm, 0 end of scan.
);
	// ********************************************
	// State.
	// ********************************************
	adsq_pkg::adsq_state_e state_q;
	logic [2:0]  channel_q;
	logic [15:0] cyc_q;
	logic        go_q;
	logic        repeat_mode_bit_q;
	logic        bias_q;
	logic        timer_trigger_enable_q;
	logic        external_trigger_enable_q;
	logic [2:0]  first_channel_field_q;
	logic        end_of_conversion_flag_q;
	logic        window_alarm_flag_q;
	logic        eoc_mask_q;
	logic        alarm_mask_q;
	logic [2:0]  prio_q;
	logic [3:0]  hit_q;
	adsq_pkg::adsq_byte_t low6_q, low7_q, up6_q, up7_q;
	logic        vec_q;
	logic        sw_req_q;

	// ********************************************
	// AXI4-Lite slave.
	// ********************************************
	logic        aw_have_q, w_have_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_fire;
	logic        ar_pend_q;
	logic [7:0]  ar_addr_q;
	logic [7:0]  mem_rd;

	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	// Address and data are latched independently, in either order.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ADSQ_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready;
			s_axi_wready  <= !w_have_q && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= s_axi_awaddr[7:0];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_q > `ADSQ_OFF_VEC) ?
					`ADSQ_RESP_SLVERR : `ADSQ_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic       wr_lane0;
	logic [7:0] wbyte;
	assign wr_lane0 = wr_fire && w_strb_q[0];
	assign wbyte    = w_data_q[7:0];

	// Reads take two cycles so the result memory output can settle.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			s_axi_arready <= 1'b0;
			ar_pend_q     <= 1'b0;
			ar_addr_q     <= 8'h00;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ADSQ_RESP_OKAY;
		end else begin
			s_axi_arready <= !ar_pend_q && !s_axi_rvalid &&
				!s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				ar_pend_q     <= 1'b1;
				ar_addr_q     <= s_axi_araddr[7:0];
				s_axi_arready <= 1'b0;
			end
			if (ar_pend_q) begin
				ar_pend_q    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `ADSQ_RESP_OKAY;
				case (ar_addr_q)
				`ADSQ_OFF_LOW6: s_axi_rdata <= {24'h0, low6_q};
				`ADSQ_OFF_LOW7: s_axi_rdata <= {24'h0, low7_q};
				`ADSQ_OFF_UP6:  s_axi_rdata <= {24'h0, up6_q};
				`ADSQ_OFF_UP7:  s_axi_rdata <= {24'h0, up7_q};
				`ADSQ_OFF_HIT:  s_axi_rdata <=
					{24'h0, hit_q, `ADSQ_HIT_LOW_ONES};
				`ADSQ_OFF_CTRL: s_axi_rdata <= {24'h0,
					first_channel_field_q, external_trigger_enable_q,
					timer_trigger_enable_q, bias_q,
					repeat_mode_bit_q, go_q};
				`ADSQ_OFF_INTC: s_axi_rdata <= {24'h0,
					end_of_conversion_flag_q, window_alarm_flag_q,
					eoc_mask_q, alarm_mask_q, 1'b1, prio_q};
				`ADSQ_OFF_VEC:  s_axi_rdata <= {31'h0, vec_q};
				default: begin
					if (ar_addr_q < `ADSQ_OFF_LOW6) begin
						s_axi_rdata <= {24'h0, mem_rd};
					end else begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `ADSQ_RESP_SLVERR;
					end
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ********************************************
	// Scan sequencer.
	// ********************************************
	logic ctrl_wr, trig, conv_end, last_ch;
	assign ctrl_wr  = wr_lane0 && aw_addr_q == `ADSQ_OFF_CTRL;
	assign trig     = (external_trigger_enable_q &&
		external_trigger_pin_i) ||
		(timer_trigger_enable_q && timer_trigger_event_i);
	assign conv_end = state_q == adsq_pkg::ADSQ_CONV &&
		cyc_q == `ADSQ_CONV_CYCLES - 16'd1;
	assign last_ch  = channel_q == `ADSQ_LAST_CH;

	// Control register and the go bit that hardware also drives.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			{first_channel_field_q, external_trigger_enable_q,
			 timer_trigger_enable_q, bias_q, repeat_mode_bit_q,
			 go_q} <= `ADSQ_CTRL_RST;
		end else if (ctrl_wr) begin
			{first_channel_field_q, external_trigger_enable_q,
			 timer_trigger_enable_q, bias_q, repeat_mode_bit_q,
			 go_q} <= wbyte;
			if (halt_i) begin
				bias_q <= 1'b0;
			end
		end else begin
			if (halt_i) begin
				bias_q <= 1'b0;
			end
			// A trigger only lands while go is low; once set, later
			// pulses are ignored in both modes.
			if (!go_q && trig) begin
				go_q <= 1'b1;
			end else if (conv_end && last_ch && !repeat_mode_bit_q) begin
				go_q <= 1'b0;
			end
		end
	end

	// Sequencing FSM; a control write aborts and restarts it.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i || ctrl_wr) begin
			state_q   <= adsq_pkg::ADSQ_IDLE;
			channel_q <= 3'h0;
			cyc_q     <= 16'h0000;
		end else begin
			case (state_q)
			adsq_pkg::ADSQ_IDLE: begin
				if (go_q) begin
					state_q   <= adsq_pkg::ADSQ_CONV;
					channel_q <= first_channel_field_q;
					cyc_q     <= 16'h0000;
				end
			end
			adsq_pkg::ADSQ_CONV: begin
				if (!go_q) begin
					state_q <= adsq_pkg::ADSQ_IDLE;
				end else if (conv_end) begin
					cyc_q <= 16'h0000;
					if (!last_ch) begin
						channel_q <= channel_q + 3'h1;
					end else if (repeat_mode_bit_q) begin
						channel_q <= first_channel_field_q;
					end else begin
						state_q <= adsq_pkg::ADSQ_DONE;
					end
				end else begin
					cyc_q <= cyc_q + 16'h0001;
				end
			end
			adsq_pkg::ADSQ_DONE: begin
				state_q <= adsq_pkg::ADSQ_IDLE;
			end
			default: state_q <= adsq_pkg::ADSQ_IDLE;
			endcase
		end
	end

	adsq_result_mem u_mem (
		.ref_clk_i (ref_clk_i),
		.wr_en_i   (conv_end && go_q),
		.wr_ch_i   (channel_q),
		.wr_data_i (conv_result_i),
		.rd_ch_i   (s_axi_araddr[4:2]),
		.rd_data_o (mem_rd)
	);

	// ********************************************
	// Thresholds, window compare and flags.
	// ********************************************
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			low6_q <= 8'h00;
			low7_q <= 8'h00;
			up6_q  <= 8'h00;
			up7_q  <= 8'h00;
		end else if (wr_lane0) begin
			if (aw_addr_q == `ADSQ_OFF_LOW6) low6_q <= wbyte;
			if (aw_addr_q == `ADSQ_OFF_LOW7) low7_q <= wbyte;
			if (aw_addr_q == `ADSQ_OFF_UP6)  up6_q  <= wbyte;
			if (aw_addr_q == `ADSQ_OFF_UP7)  up7_q  <= wbyte;
		end
	end

	logic guard, is7, over_up, under_low;
	logic [3:0] hit_set;
	assign guard     = conv_end && go_q && channel_q >= `ADSQ_CH6;
	assign is7       = channel_q[0];
	assign over_up   = conv_result_i >= (is7 ? up7_q : up6_q);
	assign under_low = conv_result_i < (is7 ? low7_q : low6_q);
	// Hit bits: 3 ch7 upper, 2 ch6 upper, 1 ch7 lower, 0 ch6 lower.
	assign hit_set = guard ? {is7 && over_up, !is7 && over_up,
		is7 && under_low, !is7 && under_low} : 4'h0;

	logic intc_wr;
	assign intc_wr = wr_lane0 && aw_addr_q == `ADSQ_OFF_INTC;

	// Hardware set wins over software clear, for every flag.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			{end_of_conversion_flag_q, window_alarm_flag_q,
			 eoc_mask_q, alarm_mask_q} <= 4'(`ADSQ_INTC_RST >> 4);
			prio_q   <= 3'(`ADSQ_INTC_RST);
			hit_q    <= 4'h0;
			sw_req_q <= 1'b0;
		end else begin
			sw_req_q <= intc_wr && (wbyte[`ADSQ_INT_EOC] ||
				wbyte[`ADSQ_INT_ALARM]);
			if (intc_wr) begin
				end_of_conversion_flag_q <= wbyte[`ADSQ_INT_EOC];
				window_alarm_flag_q      <= wbyte[`ADSQ_INT_ALARM];
				eoc_mask_q               <= wbyte[`ADSQ_INT_EOC_MSK];
				alarm_mask_q             <= wbyte[`ADSQ_INT_ALM_MSK];
				prio_q                   <= wbyte[2:0];
			end
			if (wr_lane0 && aw_addr_q == `ADSQ_OFF_HIT) begin
				hit_q <= wbyte[7:4];
			end else if (intc_wr && !wbyte[`ADSQ_INT_ALARM]) begin
				hit_q <= 4'h0;
			end
			if (|hit_set) begin
				hit_q <= hit_q | hit_set;
				window_alarm_flag_q <= 1'b1;
			end
			if (conv_end && go_q && last_ch) begin
				end_of_conversion_flag_q <= 1'b1;
			end
		end
	end

	// Request and vector: alarm outranks end of scan.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			irq_req_o <= 1'b0;
			irq_vec_o <= 1'b0;
			vec_q     <= 1'b0;
		end else begin
			irq_req_o <= (window_alarm_flag_q && alarm_mask_q) ||
				(end_of_conversion_flag_q && eoc_mask_q) ||
				sw_req_q;
			irq_vec_o <= window_alarm_flag_q && alarm_mask_q;
			vec_q     <= window_alarm_flag_q && alarm_mask_q;
		end
	end

	// Status outputs straight from flops.
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			channel_o            <= 3'h0;
			converting_o         <= 1'b0;
			analog_bias_enable_o <= 1'b0;
		end else begin
			channel_o            <= channel_q;
			converting_o         <= state_q == adsq_pkg::ADSQ_CONV;
			analog_bias_enable_o <= bias_q && !halt_i;
		end
	end

	// ********************************************
	// Checks.
	// ********************************************
	first_chan_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		state_q == adsq_pkg::ADSQ_IDLE && go_q && !ctrl_wr |=>
		channel_q == first_channel_field_q)
		else $error("scan did not start at first channel");
	single_stop_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		conv_end && last_ch && !repeat_mode_bit_q && !ctrl_wr &&
		!(!go_q && trig) |=> !go_q && end_of_conversion_flag_q)
		else $error("single scan did not stop");
	repeat_mode_bit_wrap_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		conv_end && go_q && last_ch && repeat_mode_bit_q && !ctrl_wr
		|=> channel_q == $past(first_channel_field_q) && go_q)
		else $error("continuous scan did not wrap");
	trig_set_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		!go_q && trig && !ctrl_wr |=> go_q)
		else $error("trigger did not set go");
	window_hit_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		guard && (over_up || under_low) |=> window_alarm_flag_q
		&& hit_q != 4'h0)
		else $error("window alarm missed");
	hit_low_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		s_axi_rvalid && $past(ar_addr_q) == `ADSQ_OFF_HIT &&
		$rose(s_axi_rvalid) |-> s_axi_rdata[3:0] == 4'hf)
		else $error("hit register low bits not ones");
	bias_halt_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		halt_i |=> !analog_bias_enable_o)
		else $error("bias on during halt");
	ctrl_abort_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		ctrl_wr |=> state_q == adsq_pkg::ADSQ_IDLE)
		else $error("control write did not abort");
	conv_len_a: assert property (@(posedge ref_clk_i)
		disable iff (!resetn_i)
		state_q == adsq_pkg::ADSQ_CONV && go_q && !ctrl_wr &&
		cyc_q != `ADSQ_CONV_CYCLES - 16'd1 |=>
		channel_q == $past(channel_q) &&
		cyc_q == $past(cyc_q) + 16'h0001)
		else $error("conversion ended early");
endmodule

// file: sim/adsq_far_model.sv
`timescale 1ns/1ns
// ********************************************
// Far side: analog core result and trigger sources.
// ********************************************
module adsq_far_model (
	input  wire logic       clk_i,        // Core clock.
	input  wire logic [7:0] base_i,       // Result seed set by the bench.
	input  wire logic [2:0] channel_i,    // Channel under conversion.
	input  wire logic       converting_i, // Conversion running.
	input  wire logic       fire_ext_i,   // Ask for one pin pulse.
	input  wire logic       fire_tmr_i,   // Ask for one timer event.
	output logic      [7:0] result_o,     // Analog core result.
	output logic            ext_o,        // Trigger pin.
	output logic            tmr_o         // Timer event.
);
	logic [7:0] junk_q = 8'h00;

	// Outside a conversion the bus churns, so a mistimed sample shows up.
	always @(posedge clk_i) begin
		junk_q <= junk_q + 8'h5b;
	end

	// Each channel gives base plus channel times 0x11.
	always_comb begin
		if (converting_i) begin
			result_o = base_i + {1'b0, channel_i, 1'b0, channel_i};
		end else begin
			result_o = junk_q;
		end
	end

	// Each trigger lasts exactly one core clock, the shortest legal pulse.
	initial begin
		ext_o = 1'b0;
		tmr_o = 1'b0;
	end
	always @(posedge clk_i) begin
		ext_o <= fire_ext_i;
		tmr_o <= fire_tmr_i;
	end
endmodule

// file: sim/adsq_top_tb.sv
`timescale 1ns/1ns
`include "adsq_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module adsq_top_tb;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdat, rdata;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic        rready = 0, halt = 0, fire_ext = 0, fire_tmr = 0;
	logic        awready, wready, bvalid, arready, rvalid, ext, tmr;
	logic        conv, bias, irq, vec;
	logic [1:0]  bresp, rresp, rrsp, brsp;
	logic [2:0]  chan;
	logic [7:0]  result, base = 8'h00;
	logic [31:0] seed = 32'h8eb9c512;
	int          n_fail = 0, checks = 0, cyc = 0, hit_m;
	int          exp_d[8], thr[4];

	// ****************************************
	// Clock, design and far side.
	// ****************************************
	always #4 clk = ~clk;
	adsq_top u_adsq_top (.ref_clk_i(clk), .resetn_i(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.external_trigger_pin_i(ext), .timer_trigger_event_i(tmr),
		.halt_i(halt), .conv_result_i(result), .channel_o(chan),
		.converting_o(conv), .analog_bias_enable_o(bias),
		.irq_req_o(irq), .irq_vec_o(vec));
	adsq_far_model u_adsq_far_model (.clk_i(clk), .base_i(base),
		.channel_i(chan), .converting_i(conv), .fire_ext_i(fire_ext),
		.fire_tmr_i(fire_tmr), .result_o(result), .ext_o(ext),
		.tmr_o(tmr));

	// ****************************************
	// Bus tasks and reference model.
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awaddr <= {24'h0, a};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		brsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rdat = rdata;
		rrsp = rresp;
		rready <= 1'b0;
	endtask

	// Polls the end flag; a scan that never ends is caught here.
	task automatic wait_eoc();
		int n;
		n = 0;
		do begin
			rd(`ADSQ_OFF_INTC);
			n++;
		end while (rdat[7] !== 1'b1 && n < 150);
		`CHK(rdat[7], 1'b1)
	endtask

	// Reference scan: fills results and gathers window hits.
	task automatic model_scan(input int first);
		int v;
		for (int ch = first; ch < 8; ch++) begin
			v = (base + ch * 17) % 256;
			exp_d[ch] = v;
			if (ch >= 6 && v >= thr[ch - 4]) hit_m |= (ch == 7) ? 8'h80 : 8'h40;
			if (ch >= 6 && v < thr[ch - 6]) hit_m |= (ch == 7) ? 8'h20 : 8'h10;
		end
	endtask

	task automatic chk_data(input int first);
		for (int ch = first; ch < 8; ch++) begin
			rd(8'(4 * ch));
			`CHK(rdat, 32'(exp_d[ch]))
		end
	endtask

	task automatic fire(input logic use_ext);
		@(posedge clk);
		if (use_ext) fire_ext <= 1'b1; else fire_tmr <= 1'b1;
		@(posedge clk);
		fire_ext <= 1'b0;
		fire_tmr <= 1'b0;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// A hung bus or scan ends the run here.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			results();
		end
	end

	// ****************************************
	// Tests.
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(`ADSQ_OFF_CTRL);
		`CHK(rdat, 32'h0)
		rd(`ADSQ_OFF_INTC);
		`CHK(rdat, 32'h0f)
		rd(`ADSQ_OFF_HIT);
		`CHK(rdat, 32'h0f)
		rd(8'h40);
		`CHK(rrsp, `ADSQ_RESP_SLVERR)
		wr(8'h40, 8'h00);
		`CHK(brsp, `ADSQ_RESP_SLVERR)
		$display("test reset done");
		// Bias must settle for 60 us before any conversion may start.
		wr(`ADSQ_OFF_CTRL, 8'h04);
		`CHK(brsp, `ADSQ_RESP_OKAY)
		repeat (7600) @(posedge clk);
		// Window placed on the results: ch6 at its lower edge, ch7 at upper.
		base = 8'($random(seed));
		thr[0] = (base + 102) % 256;
		thr[2] = (thr[0] + 1) % 256;
		thr[1] = (base + 119) % 256;
		thr[3] = thr[1];
		hit_m = 0;
		for (int i = 0; i < 4; i++) begin
			wr(8'(`ADSQ_OFF_LOW6 + 4 * i), 8'(thr[i]));
			rd(8'(`ADSQ_OFF_LOW6 + 4 * i));
			`CHK(rdat, 32'(thr[i]))
		end
		wr(`ADSQ_OFF_INTC, 8'h30);
		wr(`ADSQ_OFF_CTRL, 8'ha5);
		model_scan(5);
		wait_eoc();
		rd(`ADSQ_OFF_CTRL);
		`CHK(rdat, 32'ha4)
		chk_data(5);
		rd(`ADSQ_OFF_INTC);
		`CHK(rdat[6], hit_m != 0)
		rd(`ADSQ_OFF_HIT);
		`CHK(rdat, 32'(hit_m | 8'h0f))
		`CHK(irq, 1'b1)
		`CHK(vec, hit_m != 0)
		rd(`ADSQ_OFF_VEC);
		`CHK(rdat, 32'(hit_m != 0))
		wr(`ADSQ_OFF_INTC, 8'h30);
		hit_m = 0;
		rd(`ADSQ_OFF_HIT);
		`CHK(rdat, 32'h0f)
		`CHK(irq, 1'b0)
		$display("test single done");
		// Pin then timer start a channel 7 scan; each has its own enable.
		for (int s = 0; s < 2; s++) begin
			base = 8'($random(seed));
			wr(`ADSQ_OFF_CTRL, s == 0 ? 8'hf4 : 8'hec);
			fire(s == 0);
			model_scan(7);
			wait_eoc();
			chk_data(7);
			wr(`ADSQ_OFF_INTC, 8'h30);
			hit_m = 0;
		end
		wr(`ADSQ_OFF_CTRL, 8'he4);
		fire(1'b1);
		fire(1'b0);
		repeat (100) @(posedge clk);
		rd(`ADSQ_OFF_INTC);
		`CHK(rdat[7], 1'b0)
		$display("test trigger done");
		// Continuous scan keeps going past channel 7 until stopped.
		wr(`ADSQ_OFF_CTRL, 8'hc7);
		wait_eoc();
		wr(`ADSQ_OFF_INTC, 8'h30);
		wait_eoc();
		rd(`ADSQ_OFF_CTRL);
		`CHK(rdat, 32'hc7)
		wr(`ADSQ_OFF_CTRL, 8'hc4);
		repeat (2) @(posedge clk);
		`CHK(conv, 1'b0)
		`CHK(chan, 3'h0)
		$display("test continuous done");
		// Halt drops the bias; a software flag raises a request.
		`CHK(bias, 1'b1)
		halt <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK(bias, 1'b0)
		halt <= 1'b0;
		wr(`ADSQ_OFF_INTC, 8'ha0);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		`CHK(vec, 1'b0)
		$display("test halt and flag done");
		results();
	end
endmodule
